// File: rtl/prst_pkg.sv
// package for the reset and init state sequencer: bus carriers, map, reset values
// assumes a 32-bit apb master and one 100 mhz clock pclk
`default_nettype none
package prst_pkg;

	// apb carriers
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} prst_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} prst_apb_rsp_t;

	// hidden segment attributes
	typedef struct packed {
		logic g;
		logic db;
		logic l;
		logic p;
		logic [1:0] dpl;
		logic s;
		logic [3:0] typ;
	} prst_seg_attr_t;

	// sequencer states, one-hot
	typedef enum logic [4:0] {
		S_HOLD = 5'b00001,
		S_HARD = 5'b00010,
		S_TEST = 5'b00100,
		S_INIT = 5'b01000,
		S_RUN  = 5'b10000
	} prst_fsm_t;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ACC = 8'h04;
	localparam logic [7:0] OFS_IDR = 8'h08;
	localparam logic [7:0] OFS_SCW_LO = 8'h0c;
	localparam logic [7:0] OFS_SCW_HI = 8'h10;
	localparam logic [7:0] OFS_FLAGS = 8'h14;
	localparam logic [7:0] OFS_EXTENDED_FEATURES_REG = 8'h18;
	localparam logic [7:0] OFS_NFP = 8'h1c;
	localparam logic [7:0] OFS_CSSEL = 8'h20;
	localparam logic [7:0] OFS_CSBASE = 8'h24;
	localparam logic [7:0] OFS_FETCH = 8'h28;
	localparam logic [7:0] OFS_BPS = 8'h2c;
	localparam logic [7:0] OFS_BPC = 8'h30;
	localparam logic [7:0] OFS_FPCS = 8'h34;
	localparam logic [7:0] OFS_FTW = 8'h38;
	localparam logic [7:0] OFS_VCS = 8'h3c;
	localparam logic [7:0] OFS_SMB = 8'h40;
	localparam logic [7:0] OFS_TSC_LO = 8'h44;
	localparam logic [7:0] OFS_TSC_HI = 8'h48;
	localparam logic [7:0] OFS_MTYPE = 8'h4c;
	localparam logic [7:0] OFS_ATTR_CD = 8'h50;
	localparam logic [7:0] OFS_ATTR_LT = 8'h54;

	// control register fields
	localparam int CTRL_MULT_LSB = 0;
	localparam int CLK_MULT_W = 4;
	localparam int CTRL_RUN_BIT = 8;
	localparam int CTRL_FAIL_BIT = 9;
	localparam int CTRL_STEN_BIT = 10;
	localparam int CTRL_FSM_LSB = 11;

	// system control word fields
	localparam int CD_BIT = 30;
	localparam int NW_BIT = 29;
	localparam logic [63:0] CDNW_MASK = 64'h0000_0000_6000_0000;
	localparam logic [63:0] SCW_INIT_SET = 64'h0000_0000_0000_0010;

	// reset values
	localparam logic [63:0] SCW_RST = 64'h0000_0000_6000_0010;
	localparam logic [31:0] FLAGS_RST = 32'h0000_0002;
	localparam logic [31:0] EXTENDED_FEATURES_REG_RST = 32'h0000_0000;
	localparam logic [31:0] NFP_RST = 32'h0000_fff0;
	localparam logic [15:0] CS_SEL_RST = 16'hf000;
	localparam logic [31:0] CS_BASE_RST = 32'hffff_0000;
	localparam logic [31:0] BPS_RST = 32'hffff_0ff0;
	localparam logic [31:0] BPC_RST = 32'h0000_0400;
	localparam logic [15:0] FCW_RST = 16'h0040;
	localparam logic [15:0] FSW_RST = 16'h0000;
	localparam logic [15:0] FTW_RST = 16'h5555;
	localparam logic [31:0] VCS_RST = 32'h0000_1f80;
	localparam logic [31:0] SMB_RST = 32'h0003_0000;
	localparam logic [31:0] MTYPE_RST = 32'h0000_0000;
	localparam logic [31:0] TEST_FAIL_CODE = 32'h0000_0001;
	localparam logic [31:0] FETCH_FIRST = 32'hffff_fff0;

	// attributes: byte granular, 16-bit, present, privilege 0
	localparam prst_seg_attr_t ATTR_CODE = 11'b0_0_0_1_00_1_1010;
	localparam prst_seg_attr_t ATTR_DATA = 11'b0_0_0_1_00_1_0010;
	localparam prst_seg_attr_t ATTR_LDT = 11'b0_0_0_1_00_0_0010;
	localparam prst_seg_attr_t ATTR_TSS = 11'b0_0_0_1_00_0_0011;

endpackage
`default_nettype wire

// File: rtl/prst_selftest.sv
// array self-test engine: writes a pattern through an array, reads it back
// assumes start is a one-cycle pulse from the sequencer in the same clock domain
`default_nettype none
module prst_selftest #(
	parameter int unsigned DEPTH = 256,
	parameter int unsigned W = 16
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic start,
	input wire logic fault_inj,
	// result
	output logic done,
	output logic fail
);
	import prst_pkg::*;

	localparam int unsigned AW = $clog2(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

	typedef enum logic [2:0] {
		T_IDLE = 3'b001,
		T_WR = 3'b010,
		T_RD = 3'b100
	} prst_tphase_t;

	typedef struct packed {
		prst_tphase_t ph;
		logic [AW-1:0] addr;
		logic chk;
		logic [AW-1:0] chk_addr;
		logic fail;
		logic done;
	} prst_tst_t;

	prst_tst_t q, d;
	// stands in for tag, data, translation, rom and predictor arrays
	logic [W-1:0] mem [DEPTH];
	logic [W-1:0] rdat;

	function automatic logic [W-1:0] pat(input logic [AW-1:0] a);
		pat = ~W'(a);
	endfunction

	// march: one write pass, one read-compare pass
	always_comb begin
		d = q;
		d.done = 1'b0;
		d.chk = 1'b0;
		if (q.chk && rdat != pat(q.chk_addr)) begin
			d.fail = 1'b1;
		end
		if (q.chk && q.chk_addr == LAST) begin
			d.done = 1'b1;
		end
		case (q.ph)
			T_IDLE: begin
				if (start) begin
					d.ph = T_WR;
					d.addr = '0;
					d.fail = 1'b0;
				end
			end
			T_WR: begin
				d.addr = q.addr + AW'(1);
				if (q.addr == LAST) begin
					d.ph = T_RD;
					d.addr = '0;
				end
			end
			T_RD: begin
				d.chk = 1'b1;
				d.chk_addr = q.addr;
				d.addr = q.addr + AW'(1);
				if (q.addr == LAST) begin
					d.ph = T_IDLE;
				end
			end
			default: d.ph = T_IDLE;
		endcase
	end

	// array port, no reset on the storage
	always_ff @(posedge pclk) begin
		if (q.ph == T_WR) begin
			mem[q.addr] <= pat(q.addr) ^ W'(fault_inj);
		end
		rdat <= mem[q.addr];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '{ph: T_IDLE, addr: '0, chk: 1'b0, chk_addr: '0, fail: 1'b0, done: 1'b0};
		end else begin
			q <= d;
		end
	end

	assign done = q.done;
	assign fail = q.fail;

endmodule // prst_selftest
`default_nettype wire

// File: rtl/prst_top.sv
// reset and init state sequencer with apb register access
// assumes hard_rst_n and init_req are synchronous to pclk; pclk is the core clock
// Contract
// - both events give real mode, known state
// - init keeps caches, media, x87, ranges, machine-check
// - init touches some model registers only
// - self-test runs only under hard reset
// - hard reset at power-up, both later
// - accumulator zero on pass, non-zero on fault; an init held pending through the test clears it
// - self-test walks the internal arrays
// - execution waits for self-test completion
// - core clock is selectable system multiple
// - hard reset loads control word; init keeps cache pair
// - init sets bit 4, clears the rest except the cache pair
// - pointer and code segment same for both
// - hidden attributes fixed per segment kind
// - identification result loaded after reset
// - hard reset loads fp, media state
// - hard reset invalidates caches and buffers
// - hard reset loads save base only
// - first fetch at top, base until reload
// - stamp counter cleared, counts, init keeps
`default_nettype none
module prst_top #(
	parameter logic [31:0] ID_VALUE = 32'h0001_0f21, // arbitrary identity value
	parameter logic [3:0] CLK_MULT_DEF = 4'h4,
	parameter int unsigned TEST_DEPTH = 256
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire prst_pkg::prst_apb_req_t apb_req,
	output prst_pkg::prst_apb_rsp_t apb_rsp,
	// system signalling
	input wire logic hard_rst_n,
	input wire logic init_req,
	input wire logic self_test_en,
	input wire logic self_test_fault,
	// core side
	output logic core_run,
	output logic [31:0] fetch_addr,
	output logic [3:0] clk_mult,
	output logic cache_inval,
	output logic media_clear,
	output logic test_busy
);
	import prst_pkg::*;

	typedef struct packed {
		prst_fsm_t fsm;
		logic pend_init;
		logic st_en;
		logic st_start;
		logic st_fail;
		logic [63:0] scw;
		logic [31:0] flags;
		logic [31:0] extended_features_reg;
		logic [31:0] nfp;
		logic [15:0] cs_sel;
		logic [31:0] cs_base;
		logic [31:0] fetch;
		logic [31:0] bps;
		logic [31:0] bpc;
		logic [15:0] fcw;
		logic [15:0] fsw;
		logic [15:0] ftw;
		logic [31:0] vcs;
		logic [31:0] smb;
		logic [63:0] cycle_stamp_counter;
		logic [31:0] acc;
		logic [31:0] idr;
		logic [31:0] mtype;
		logic [3:0] mult;
		logic run;
		logic cache_inv;
		logic media_clr;
		logic busy;
		prst_apb_rsp_t rsp;
	} prst_top_st_t;

	prst_top_st_t q, d;
	logic st_done;
	logic st_fail;

	// array self-test engine
	prst_selftest #(
		.DEPTH(TEST_DEPTH),
		.W(16)
	) u_test (
		.pclk(pclk),
		.presetn(presetn),
		.start(q.st_start),
		.fault_inj(self_test_fault),
		.done(st_done),
		.fail(st_fail)
	);

	// read mux, bit 32 flags an unmapped offset
	function automatic logic [32:0] rd_word(input prst_top_st_t s, input logic [7:0] a);
		rd_word = 33'h0_0000_0000;
		case (a)
			OFS_CTRL: begin
				rd_word[CTRL_MULT_LSB +: CLK_MULT_W] = s.mult;
				rd_word[CTRL_RUN_BIT] = s.run;
				rd_word[CTRL_FAIL_BIT] = s.st_fail;
				rd_word[CTRL_STEN_BIT] = s.st_en;
				rd_word[CTRL_FSM_LSB +: 5] = s.fsm;
			end
			OFS_ACC: rd_word[31:0] = s.acc;
			OFS_IDR: rd_word[31:0] = s.idr;
			OFS_SCW_LO: rd_word[31:0] = s.scw[31:0];
			OFS_SCW_HI: rd_word[31:0] = s.scw[63:32];
			OFS_FLAGS: rd_word[31:0] = s.flags;
			OFS_EXTENDED_FEATURES_REG: rd_word[31:0] = s.extended_features_reg;
			OFS_NFP: rd_word[31:0] = s.nfp;
			OFS_CSSEL: rd_word[15:0] = s.cs_sel;
			OFS_CSBASE: rd_word[31:0] = s.cs_base;
			OFS_FETCH: rd_word[31:0] = s.fetch;
			OFS_BPS: rd_word[31:0] = s.bps;
			OFS_BPC: rd_word[31:0] = s.bpc;
			OFS_FPCS: rd_word[31:0] = {s.fsw, s.fcw};
			OFS_FTW: rd_word[15:0] = s.ftw;
			OFS_VCS: rd_word[31:0] = s.vcs;
			OFS_SMB: rd_word[31:0] = s.smb;
			OFS_TSC_LO: rd_word[31:0] = s.cycle_stamp_counter[31:0];
			OFS_TSC_HI: rd_word[31:0] = s.cycle_stamp_counter[63:32];
			OFS_MTYPE: rd_word[31:0] = s.mtype;
			OFS_ATTR_CD: rd_word[31:0] = {5'h00, ATTR_DATA, 5'h00, ATTR_CODE};
			OFS_ATTR_LT: rd_word[31:0] = {5'h00, ATTR_TSS, 5'h00, ATTR_LDT};
			default: rd_word[32] = 1'b1;
		endcase
	endfunction

	// bus, sequencer and architectural state
	always_comb begin
		logic [32:0] rw;
		rw = rd_word(q, apb_req.paddr);
		d = q;
		d.cycle_stamp_counter = q.cycle_stamp_counter + 64'h1; // one count per core clock
		d.st_start = 1'b0;
		d.cache_inv = 1'b0;
		d.media_clr = 1'b0;
		d.rsp.pready = 1'b0;
		d.rsp.pslverr = 1'b0;
		// first access cycle: fetch data, answer next edge
		if (apb_req.psel && apb_req.penable && !q.rsp.pready) begin
			d.rsp.pready = 1'b1;
			d.rsp.pslverr = rw[32];
			d.rsp.prdata = rw[31:0];
		end
		// write takes effect on the edge that sees pready
		// a load further down overrides a write of the same cycle
		if (apb_req.psel && apb_req.penable && q.rsp.pready && apb_req.pwrite) begin
			case (apb_req.paddr)
				OFS_CTRL: d.mult = apb_req.pwdata[CTRL_MULT_LSB +: CLK_MULT_W];
				OFS_SCW_LO: d.scw[31:0] = apb_req.pwdata;
				OFS_SCW_HI: d.scw[63:32] = apb_req.pwdata;
				OFS_FLAGS: d.flags = apb_req.pwdata;
				OFS_EXTENDED_FEATURES_REG: d.extended_features_reg = apb_req.pwdata;
				OFS_NFP: d.nfp = apb_req.pwdata;
				OFS_CSSEL: begin
					d.cs_sel = apb_req.pwdata[15:0];
					d.cs_base = {12'h000, apb_req.pwdata[15:0], 4'h0}; // reload ends top base
				end
				OFS_BPS: d.bps = apb_req.pwdata;
				OFS_BPC: d.bpc = apb_req.pwdata;
				OFS_FPCS: {d.fsw, d.fcw} = apb_req.pwdata;
				OFS_FTW: d.ftw = apb_req.pwdata[15:0];
				OFS_VCS: d.vcs = apb_req.pwdata;
				OFS_SMB: d.smb = apb_req.pwdata;
				OFS_TSC_LO: d.cycle_stamp_counter[31:0] = apb_req.pwdata;
				OFS_TSC_HI: d.cycle_stamp_counter[63:32] = apb_req.pwdata;
				OFS_MTYPE: d.mtype = apb_req.pwdata;
				default: d.mult = q.mult;
			endcase
		end
		case (q.fsm)
			// held in reset until the pin releases
			S_HOLD: begin
				if (hard_rst_n) begin
					d.fsm = S_HARD;
				end
			end
			// full load of every resource except the clock multiple and the fail flag
			S_HARD: begin
				d.scw = SCW_RST; // real mode, caches off
				d.fcw = FCW_RST;
				d.fsw = FSW_RST;
				d.ftw = FTW_RST;
				d.vcs = VCS_RST;
				d.media_clr = 1'b1; // stack and vector registers clear
				d.cache_inv = 1'b1; // caches and translation buffers
				d.smb = SMB_RST;
				d.cycle_stamp_counter = 64'h0;
				d.mtype = MTYPE_RST; // range default cleared
				d.st_en = self_test_en; // strap caught after release
				if (self_test_en) begin
					d.st_start = 1'b1; // only path that starts the
					d.fsm = S_TEST;
				end else begin
					d.fsm = S_RUN;
				end
			end
			// wait out the self-test; an init is kept pending
			S_TEST: begin
				if (init_req) begin
					d.pend_init = 1'b1;
				end
				if (st_done) begin
					d.st_fail = st_fail;
					d.acc = st_fail ? TEST_FAIL_CODE : 32'h0;
					d.fsm = (q.pend_init || init_req) ? S_INIT : S_RUN;
				end
			end
			// partial load; caches, fp, media, ranges untouched
			S_INIT: begin
				d.scw = (q.scw & CDNW_MASK) | SCW_INIT_SET;
				d.pend_init = 1'b0;
				d.acc = 32'h0;
				d.fsm = S_RUN;
			end
			S_RUN: begin
				if (init_req) begin
					d.fsm = S_INIT; // init accepted in run; during self-test it is held pending
				end
			end
			default: d.fsm = S_HOLD;
		endcase
		// common part of both loads, same values
		if (q.fsm == S_HARD || q.fsm == S_INIT) begin
			d.flags = FLAGS_RST;
			d.extended_features_reg = EXTENDED_FEATURES_REG_RST; // model register that init does touch
			d.nfp = NFP_RST;
			d.cs_sel = CS_SEL_RST;
			d.cs_base = CS_BASE_RST;
			d.bps = BPS_RST;
			d.bpc = BPC_RST;
			d.idr = ID_VALUE;
			if (q.fsm == S_HARD) begin
				d.acc = 32'h0;
			end
		end
		// the pin overrides the next state, a pending init is dropped
		if (!hard_rst_n) begin
			d.fsm = S_HOLD;
			d.pend_init = 1'b0;
		end
		d.fetch = d.cs_base + d.nfp;
		d.run = (d.fsm == S_RUN);
		// busy flag registered so the pin comes from a flop
		d.busy = (d.fsm == S_TEST);
	end

	// state register; power-up enters the hard reset path
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.fsm <= S_HOLD;
			q.mult <= CLK_MULT_DEF;
		end else begin
			q <= d;
		end
	end

	// outputs straight from the state register
	assign apb_rsp = q.rsp;
	assign core_run = q.run;
	assign fetch_addr = q.fetch;
	assign clk_mult = q.mult;
	assign cache_inval = q.cache_inv;
	assign media_clear = q.media_clr;
	assign test_busy = q.busy;

	// checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_hard_scw_load: assert property ((q.fsm == S_HARD) |=> (q.scw == SCW_RST && q.smb == SMB_RST))
		else $error("hard reset control word or save base wrong");
	a_init_scw_form: assert property ((q.fsm == S_INIT) |=> (q.scw == (($past(q.scw) & CDNW_MASK) | SCW_INIT_SET)))
		else $error("init control word form wrong");
	a_init_keeps_fp: assert property ((q.fsm == S_INIT) |=> ($stable(q.fcw) && $stable(q.ftw) && $stable(q.vcs)
		&& $stable(q.smb) && $stable(q.mtype) && !q.cache_inv && !q.media_clr))
		else $error("init disturbed preserved state");
	a_tsc_count: assert property ((q.fsm == S_INIT) |=> (q.cycle_stamp_counter == $past(q.cycle_stamp_counter) + 64'h1))
		else $error("stamp counter not kept across init");
	a_tsc_clear: assert property ((q.fsm == S_HARD) |=> (q.cycle_stamp_counter == 64'h0) ##1 (q.cycle_stamp_counter == 64'h1))
		else $error("stamp counter not cleared and counting");
	a_test_only_hard: assert property (q.st_start |-> ($past(q.fsm) == S_HARD && q.st_en))
		else $error("self-test started outside hard reset");
	a_test_blocks_run: assert property ((q.fsm == S_TEST) |-> !core_run)
		else $error("core ran during self-test");
	a_test_result: assert property ((q.fsm == S_TEST && st_done && hard_rst_n) |=> ((q.acc == 32'h0) == !q.st_fail))
		else $error("accumulator does not match test result");
	a_first_fetch: assert property (((q.fsm == S_HARD || q.fsm == S_INIT) && hard_rst_n)
		|=> ##1 (fetch_addr == FETCH_FIRST))
		else $error("first fetch address wrong");
	a_hard_wins: assert property ((!hard_rst_n && init_req) |=> (q.fsm == S_HOLD && !q.pend_init))
		else $error("init not overridden by hard reset");
	a_apb_one_shot: assert property (apb_rsp.pready |=> !apb_rsp.pready) // apb handshake
		else $error("pready held longer than one cycle");

	// values one cycle after each load
	a_hard_fp_load: assert property ((q.fsm == S_HARD)
		|=> (q.fcw == FCW_RST && q.fsw == FSW_RST && q.ftw == FTW_RST && q.vcs == VCS_RST))
		else $error("hard reset floating-point or media load wrong");
	a_hard_inval: assert property ((q.fsm == S_HARD)
		|=> (cache_inval && media_clear))
		else $error("hard reset did not pulse invalidate and clear");
	a_hard_acc_zero: assert property (((q.fsm == S_HARD) && !self_test_en)
		|=> (q.acc == 32'h0))
		else $error("accumulator not cleared by hard reset");
	a_init_common: assert property ((q.fsm == S_INIT)
		|=> (q.nfp == NFP_RST && q.cs_sel == CS_SEL_RST && q.cs_base == CS_BASE_RST && q.flags == FLAGS_RST))
		else $error("init common load wrong");
	a_id_debug_load: assert property (((q.fsm == S_HARD) || (q.fsm == S_INIT))
		|=> (q.bps == BPS_RST && q.bpc == BPC_RST && q.idr == ID_VALUE))
		else $error("identification or breakpoint load wrong");
	a_init_extended_features_reg: assert property ((q.fsm == S_INIT)
		|=> (q.extended_features_reg == EXTENDED_FEATURES_REG_RST))
		else $error("init did not clear extended features");

	// init sequencing
	a_run_after_init: assert property (((q.fsm == S_INIT) && hard_rst_n)
		|=> core_run)
		else $error("execution not released after init");
	a_init_no_test: assert property ((q.fsm == S_INIT)
		|=> (!q.st_start && !test_busy))
		else $error("init started the self-test");
	a_init_deferred: assert property (((q.fsm == S_TEST) && st_done && hard_rst_n && (q.pend_init || init_req))
		|=> (q.fsm == S_INIT))
		else $error("pending init not applied after self-test");

	c_hard_no_test: cover property ((q.fsm == S_HARD && !self_test_en) ##1 core_run);
	c_test_fail: cover property ((q.fsm == S_TEST) ##[1:1000] (st_done && st_fail));
	c_init_in_run: cover property ((q.fsm == S_RUN && init_req) ##2 core_run);
	c_init_pending: cover property ((q.fsm == S_TEST && init_req) ##[1:1000] (q.fsm == S_INIT));
	c_both_events: cover property ((!hard_rst_n && init_req) ##3 core_run);

endmodule // prst_top
`default_nettype wire

// File: tb/prst_sys_model.sv
// system-side model: drives the hard reset pin and the init request line
// assumes one bench process calls its tasks, each entered just after a pclk edge
`default_nettype none
module prst_sys_model (
	// clock
	input wire logic pclk,
	// event signalling
	output logic hard_rst_n,
	output logic init_req
);
	timeunit 1ns;
	timeprecision 1ns;

	// idle: pin released, no request
	initial begin
		hard_rst_n = 1'b1;
		init_req = 1'b0;
	end

	// hard reset pin held low for n cycles
	task automatic hard_pulse(input int n);
		hard_rst_n <= 1'b0;
		repeat (n) @(posedge pclk);
		hard_rst_n <= 1'b1;
	endtask

	// init on its own line, one cycle, pin untouched
	task automatic init_pulse();
		init_req <= 1'b1;
		@(posedge pclk);
		init_req <= 1'b0;
	endtask

	// both events raised in the same cycle
	task automatic both_pulse();
		hard_rst_n <= 1'b0;
		init_req <= 1'b1;
		@(posedge pclk);
		hard_rst_n <= 1'b1;
		init_req <= 1'b0;
	endtask
endmodule // prst_sys_model
`default_nettype wire

// File: tb/prst_top_test.sv
// bench for the reset and init sequencer: apb master, one task per scenario
// assumes prst_top with a short self-test and the system model on the event pins
`default_nettype none
module prst_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	import prst_pkg::*;
	localparam logic [31:0] ID_TB = 32'h0000_0a5c; // arbitrary value
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	prst_apb_req_t apb_req = '0;
	prst_apb_rsp_t apb_rsp;
	logic hard_rst_n, init_req, core_run, cache_inval, media_clear, test_busy, rerr;
	logic self_test_en = 1'b0;
	logic self_test_fault = 1'b0;
	logic [31:0] fetch_addr, rdat;
	logic [3:0] clk_mult;
	int fails = 0;
	int n_checks = 0;
	int n_inval = 0;
	int n_media = 0;
	int n_busy = 0;

	// clock, 100 mhz
	always #5 pclk = ~pclk;

	prst_top #(.ID_VALUE(ID_TB), .TEST_DEPTH(8)) i_prst_top (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
		.apb_rsp(apb_rsp), .hard_rst_n(hard_rst_n), .init_req(init_req), .self_test_en(self_test_en),
		.self_test_fault(self_test_fault), .core_run(core_run), .fetch_addr(fetch_addr), .clk_mult(clk_mult),
		.cache_inval(cache_inval), .media_clear(media_clear), .test_busy(test_busy));
	prst_sys_model i_prst_sys_model (.pclk(pclk), .hard_rst_n(hard_rst_n), .init_req(init_req));

	// count load strobes and self-test cycles
	always @(posedge pclk) begin
		n_inval <= n_inval + int'(cache_inval === 1'b1);
		n_media <= n_media + int'(media_clear === 1'b1);
		n_busy <= n_busy + int'(test_busy === 1'b1);
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (apb_rsp.pready !== 1'b1 && k < 20);
		rdat = apb_rsp.prdata;
		rerr = apb_rsp.pslverr;
		apb_req <= '0;
		chk("pready", 32'h1, {31'h0, apb_rsp.pready});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(a, 1'b0, 32'h0);
		chk($sformatf("offset %h", a), exp, rdat);
	endtask

	// bounded wait for execution to be released
	task automatic wait_run();
		int k;
		k = 0;
		repeat (3) @(posedge pclk);
		while (core_run !== 1'b1 && k < 500) begin
			@(posedge pclk);
			k++;
		end
		chk("core_run", 32'h1, {31'h0, core_run});
	endtask

	task automatic t_power_up();
		logic [7:0] ofs [18] = '{OFS_SCW_LO, OFS_SCW_HI, OFS_FLAGS, OFS_EXTENDED_FEATURES_REG, OFS_NFP, OFS_CSSEL, OFS_CSBASE,
			OFS_FETCH, OFS_BPS, OFS_BPC, OFS_FPCS, OFS_FTW, OFS_VCS, OFS_SMB, OFS_ATTR_CD, OFS_ATTR_LT, OFS_ACC, OFS_IDR};
		logic [31:0] val [18] = '{32'h6000_0010, 32'h0, 32'h2, 32'h0, 32'h0000_fff0, 32'h0000_f000, 32'hffff_0000,
			32'hffff_fff0, 32'hffff_0ff0, 32'h0000_0400, 32'h0000_0040, 32'h0000_5555, 32'h0000_1f80, 32'h0003_0000,
			32'h0092_009a, 32'h0083_0082, 32'h0, ID_TB};
		logic [31:0] t0;
		foreach (ofs[i]) rd(ofs[i], val[i]);
		chk("fetch_addr", 32'hffff_fff0, fetch_addr);
		chk("inval pulses", 32'h1, n_inval);
		chk("media pulses", 32'h1, n_media);
		rd(OFS_TSC_HI, 32'h0);
		apb(OFS_TSC_LO, 1'b0, 32'h0);
		t0 = rdat;
		apb(OFS_TSC_LO, 1'b0, 32'h0);
		chk("stamp advances", 32'h1, {31'h0, rdat > t0});
	endtask

	task automatic t_init_keep();
		logic [7:0] ofs [12] = '{OFS_SCW_LO, OFS_SCW_HI, OFS_FLAGS, OFS_EXTENDED_FEATURES_REG, OFS_NFP, OFS_CSSEL, OFS_FPCS,
			OFS_FTW, OFS_VCS, OFS_SMB, OFS_MTYPE, OFS_TSC_HI};
		logic [31:0] wv [12] = '{32'h2000_0005, 32'h0000_0001, 32'h0000_0046, 32'h0000_0100, 32'h0000_1234,
			32'h0000_1234, 32'h0001_037f, 32'h0000_ffff, 32'h0000_1f00, 32'h000a_0000, 32'h0000_0c06, 32'h0000_0005};
		logic [31:0] ev [12] = '{32'h2000_0010, 32'h0, 32'h2, 32'h0, 32'h0000_fff0, 32'h0000_f000, 32'h0001_037f,
			32'h0000_ffff, 32'h0000_1f00, 32'h000a_0000, 32'h0000_0c06, 32'h0000_0005};
		int bi;
		int bm;
		foreach (ofs[i]) apb(ofs[i], 1'b1, wv[i]);
		rd(OFS_CSBASE, 32'h0001_2340);
		rd(OFS_FETCH, 32'h0001_3574);
		bi = n_inval;
		bm = n_media;
		i_prst_sys_model.init_pulse();
		wait_run();
		foreach (ofs[i]) rd(ofs[i], ev[i]);
		rd(OFS_CSBASE, 32'hffff_0000);
		rd(OFS_FETCH, 32'hffff_fff0);
		rd(OFS_ACC, 32'h0);
		chk("inval on init", 32'h0, n_inval - bi);
		chk("media on init", 32'h0, n_media - bm);
	endtask

	task automatic t_self_test(input logic flt);
		int k;
		k = 0;
		self_test_en <= 1'b1;
		self_test_fault <= flt;
		i_prst_sys_model.hard_pulse(2);
		while (test_busy !== 1'b1 && k < 20) begin
			@(posedge pclk);
			k++;
		end
		chk("test_busy", 32'h1, {31'h0, test_busy});
		chk("run in test", 32'h0, {31'h0, core_run});
		wait_run();
		self_test_en <= 1'b0;
		self_test_fault <= 1'b0;
		rd(OFS_ACC, flt ? 32'h1 : 32'h0);
		apb(OFS_CTRL, 1'b0, 32'h0);
		chk("fail flag", {31'h0, flt}, {31'h0, rdat[CTRL_FAIL_BIT]});
		rd(OFS_SCW_LO, 32'h6000_0010);
		rd(OFS_FPCS, 32'h0000_0040);
		rd(OFS_SMB, 32'h0003_0000);
		rd(OFS_TSC_HI, 32'h0);
	endtask

	// init raised while a failing self-test runs: deferred, then applied
	task automatic t_init_in_test();
		self_test_en <= 1'b1;
		self_test_fault <= 1'b1;
		i_prst_sys_model.hard_pulse(2);
		repeat (4) @(posedge pclk);
		chk("busy before init", 32'h1, {31'h0, test_busy});
		i_prst_sys_model.init_pulse();
		wait_run();
		self_test_en <= 1'b0;
		self_test_fault <= 1'b0;
		rd(OFS_ACC, 32'h0);
		apb(OFS_CTRL, 1'b0, 32'h0);
		chk("fail flag kept", 32'h1, {31'h0, rdat[CTRL_FAIL_BIT]});
	endtask

	task automatic t_init_no_test();
		int b;
		b = n_busy;
		self_test_en <= 1'b1;
		i_prst_sys_model.init_pulse();
		wait_run();
		self_test_en <= 1'b0;
		chk("busy on init", 32'h0, n_busy - b);
		rd(OFS_ACC, 32'h0);
	endtask

	task automatic t_both();
		int bi;
		apb(OFS_SMB, 1'b1, 32'h0005_0000);
		apb(OFS_FTW, 1'b1, 32'h0000_1111);
		bi = n_inval;
		i_prst_sys_model.both_pulse();
		wait_run();
		rd(OFS_SMB, 32'h0003_0000);
		rd(OFS_FTW, 32'h0000_5555);
		chk("inval on both", 32'h1, n_inval - bi);
	endtask

	task automatic t_bus();
		apb(8'hfc, 1'b0, 32'h0);
		chk("pslverr", 32'h1, {31'h0, rerr});
		apb(OFS_IDR, 1'b1, 32'h1234_5678);
		rd(OFS_IDR, ID_TB);
		apb(OFS_CTRL, 1'b1, 32'h0000_0007);
		@(posedge pclk);
		chk("clk_mult", 32'h7, {28'h0, clk_mult});
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		wait_run();
		t_power_up();
		t_init_keep();
		t_self_test(1'b0);
		t_self_test(1'b1);
		t_init_in_test();
		t_init_no_test();
		t_both();
		t_bus();
		stop_test();
	end

	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge pclk);
		fails++;
		$display("CHECK FAILED watchdog expected finish seen timeout");
		stop_test();
	end
endmodule // prst_top_test
`default_nettype wire
